// *** hw/imd_regs.svh ***
// Register map, field positions and code points of the immediate/move opcode decoder.
// Assumes inclusion by the design modules and the bench by bare name.
`ifndef IMD_REGS_SVH
`define IMD_REGS_SVH
`define IMD_ADDR_W 8
`define IMD_OFS_OPWORD 8'h00
`define IMD_OFS_EXTWORD 8'h04
`define IMD_OFS_CTRL 8'h08
`define IMD_OFS_RESULT0 8'h0c
`define IMD_OFS_RESULT1 8'h10
`define IMD_OFS_COUNT 8'h14
`define IMD_CTRL_RST 1'h1
`define IMD_RESP_OKAY 2'h0
`define IMD_RESP_SLVERR 2'h2
`define IMD_LINE_IMM 4'h0
`define IMD_LINE_MOVB 4'h1
`define IMD_LINE_MOVL 4'h2
`define IMD_LINE_MOVW 4'h3
`define IMD_LINE_MISC 4'h4
`define IMD_LINE_COP 4'hf
`define IMD_SUB_OR 4'h0
`define IMD_SUB_AND 4'h2
`define IMD_SUB_SUB 4'h4
`define IMD_SUB_ADD 4'h6
`define IMD_SUB_BIT 4'h8
`define IMD_SUB_XOR 4'ha
`define IMD_SUB_CMP 4'hc
`define IMD_SUB_ALT 4'he
`define IMD_LOW_CCR 8'h3c
`define IMD_LOW_SR 8'h7c
`define IMD_SIZE_BAD 2'h3
`define IMD_MODE_AREG 3'h1
`define IMD_NEGATE_WITH_EXTEND_HI 4'h0
`define IMD_EXT_DIR_BIT 11
`endif

// *** hw/imd_pkg.sv ***
// Types shared by the opcode decoder modules.
// Assumes the header of constants is on the include path.
package imd_pkg;
    typedef enum logic [1:0] {
        IMD_SZ_BYTE = 2'h0,
        IMD_SZ_WORD = 2'h1,
        IMD_SZ_LONG = 2'h2,
        IMD_SZ_NONE = 2'h3
    } imd_size_t;
    typedef enum logic [1:0] {
        IMD_BIT_TEST = 2'h0,
        IMD_BIT_CHANGE = 2'h1,
        IMD_BIT_CLEAR = 2'h2,
        IMD_BIT_SET = 2'h3
    } imd_bitop_t;
    typedef enum logic [1:0] {
        IMD_TGT_EA = 2'h0,
        IMD_TGT_CCR = 2'h1,
        IMD_TGT_SR = 2'h2
    } imd_tgt_t;
    typedef enum logic [3:0] {
        IMD_OP_OTHER = 4'h0,
        IMD_OP_OR = 4'h1,
        IMD_OP_AND = 4'h2,
        IMD_OP_SUB = 4'h3,
        IMD_OP_ADD = 4'h4,
        IMD_OP_XOR = 4'h5,
        IMD_OP_CMP = 4'h6,
        IMD_OP_BIT = 4'h7,
        IMD_OP_ALT_MOVE = 4'h8,
        IMD_OP_MOVE = 4'h9,
        IMD_OP_ADDR_MOVE = 4'ha,
        IMD_OP_NEGATE_WITH_EXTEND = 4'hb,
        IMD_OP_COPROC = 4'hc
    } imd_op_t;
endpackage

// *** hw/imd_decode.sv ***
// Combinational field decoder for one primary word and its first extension word.
// Assumes both words are stable registers in the caller's clock domain.
`timescale 1ns/1ps
`include "imd_regs.svh"
module imd_decode
    import imd_pkg::*;
(
    input wire logic [15:0] word_i, // primary word
    input wire logic [15:0] ext_i, // first extension word
    output imd_op_t op_o, // operation class
    output imd_size_t size_o, // operand size
    output imd_tgt_t tgt_o, // destination kind
    output imd_bitop_t bitop_o, // static bit operation
    output logic dir_o, // transfer direction
    output logic illegal_o, // word must trap
    output logic [2:0] src_mode_o, // source mode
    output logic [2:0] src_reg_o, // source register
    output logic [2:0] dst_mode_o, // destination mode
    output logic [2:0] dst_reg_o // destination register
);
    logic [3:0] line;
    logic [3:0] sub;
    logic [1:0] szf;
    assign line = word_i[15:12];
    assign sub = word_i[11:8];
    assign szf = word_i[7:6];

    always_comb begin
        op_o = IMD_OP_OTHER;
        size_o = IMD_SZ_NONE;
        tgt_o = IMD_TGT_EA;
        bitop_o = IMD_BIT_TEST;
        dir_o = 1'b0;
        illegal_o = 1'b0;
        src_mode_o = word_i[5:3];
        src_reg_o = word_i[2:0];
        dst_mode_o = word_i[5:3];
        dst_reg_o = word_i[2:0];
        unique case (line)
            `IMD_LINE_IMM: begin
                if (!word_i[8]) begin
                    size_o = imd_size_t'(szf);
                    illegal_o = (szf == `IMD_SIZE_BAD);
                    unique case (sub)
                        `IMD_SUB_OR: op_o = IMD_OP_OR;
                        `IMD_SUB_AND: op_o = IMD_OP_AND;
                        `IMD_SUB_SUB: op_o = IMD_OP_SUB;
                        `IMD_SUB_ADD: op_o = IMD_OP_ADD;
                        `IMD_SUB_XOR: op_o = IMD_OP_XOR;
                        `IMD_SUB_CMP: op_o = IMD_OP_CMP;
                        `IMD_SUB_ALT: begin
                            op_o = IMD_OP_ALT_MOVE;
                            dir_o = ext_i[`IMD_EXT_DIR_BIT];
                        end
                        `IMD_SUB_BIT: begin
                            op_o = IMD_OP_BIT;
                            size_o = IMD_SZ_NONE;
                            illegal_o = 1'b0;
                            bitop_o = imd_bitop_t'(szf);
                        end
                        default: begin
                            op_o = IMD_OP_OTHER;
                            size_o = IMD_SZ_NONE;
                            illegal_o = 1'b0;
                        end
                    endcase
                    // The status forms reuse size codes, so they are split out after the trap check and override the target and size.
                    if (sub == `IMD_SUB_OR || sub == `IMD_SUB_AND || sub == `IMD_SUB_XOR) begin
                        if (word_i[7:0] == `IMD_LOW_CCR) begin
                            tgt_o = IMD_TGT_CCR;
                            size_o = IMD_SZ_BYTE;
                        end else if (word_i[7:0] == `IMD_LOW_SR) begin
                            tgt_o = IMD_TGT_SR;
                            size_o = IMD_SZ_WORD;
                        end
                    end
                end
            end
            `IMD_LINE_MOVB, `IMD_LINE_MOVL, `IMD_LINE_MOVW: begin
                dst_reg_o = word_i[11:9];
                dst_mode_o = word_i[8:6];
                op_o = (word_i[8:6] == `IMD_MODE_AREG) ? IMD_OP_ADDR_MOVE : IMD_OP_MOVE;
                unique case (line)
                    `IMD_LINE_MOVB: size_o = IMD_SZ_BYTE;
                    `IMD_LINE_MOVL: size_o = IMD_SZ_LONG;
                    default: size_o = IMD_SZ_WORD;
                endcase
                // An address-register destination takes no byte operand.
                illegal_o = (line == `IMD_LINE_MOVB) && (word_i[8:6] == `IMD_MODE_AREG);
            end
            `IMD_LINE_MISC: begin
                if (sub == `IMD_NEGATE_WITH_EXTEND_HI && szf != `IMD_SIZE_BAD) begin
                    op_o = IMD_OP_NEGATE_WITH_EXTEND;
                    size_o = imd_size_t'(szf);
                end
            end
            `IMD_LINE_COP: op_o = IMD_OP_COPROC;
            default: op_o = IMD_OP_OTHER;
        endcase
    end
endmodule

// *** hw/imd_top.sv ***
// AXI4-Lite wrapper of the opcode decoder: word registers, decode capture and result readback.
// Assumes one clock; the fetch port and the bus master share it.
`timescale 1ns/1ps
`include "imd_regs.svh"
module imd_top
    import imd_pkg::*;
(
    input wire logic clk_i, // 100 MHz clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic fetch_valid_i, // fetch offers a word pair
    input wire logic [15:0] fetch_word_i, // fetched primary word
    input wire logic [15:0] fetch_ext_i, // fetched extension word
    output logic dec_valid_o, // decode result pulse
    output logic [3:0] dec_op_o, // decoded operation
    output logic [1:0] dec_size_o, // decoded size
    output logic dec_illegal_o, // illegal word
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    logic rst_sync1_ff;
    logic rst_sync2_ff;
    logic rst_n;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync1_ff <= 1'b0;
            rst_sync2_ff <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_sync2_ff <= rst_sync1_ff;
        end
    end
    assign rst_n = rst_sync2_ff;

    // Write channel: address and data are latched independently, in either order.
    logic aw_held_ff;
    logic w_held_ff;
    logic awready_ff;
    logic wready_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic do_write;
    logic wr_map;
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_map = (aw_addr_ff == `IMD_OFS_OPWORD) || (aw_addr_ff == `IMD_OFS_EXTWORD) ||
                    (aw_addr_ff == `IMD_OFS_CTRL);
    // The ready flags are flops of their own, so that no gate stands between a flop and the bus.
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `IMD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_ff) begin
                aw_held_ff <= 1'b1;
                awready_ff <= 1'b0;
                aw_addr_ff <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && !w_held_ff) begin
                w_held_ff <= 1'b1;
                wready_ff <= 1'b0;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_map ? `IMD_RESP_OKAY : `IMD_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
        end
    end

    // Word and control registers; a fetch offer wins over a software write in the same cycle.
    logic [15:0] opword_ff;
    logic [15:0] extword_ff;
    logic enable_ff;
    logic pending_ff;
    logic sw_op;
    logic sw_ext;
    assign sw_op = do_write && (aw_addr_ff == `IMD_OFS_OPWORD);
    assign sw_ext = do_write && (aw_addr_ff == `IMD_OFS_EXTWORD);

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            opword_ff <= 16'h0;
            extword_ff <= 16'h0;
        end else if (fetch_valid_i) begin
            opword_ff <= fetch_word_i;
            extword_ff <= fetch_ext_i;
        end else begin
            if (sw_op) begin
                opword_ff <= merge16(opword_ff, w_data_ff, w_strb_ff);
            end
            if (sw_ext) begin
                extword_ff <= merge16(extword_ff, w_data_ff, w_strb_ff);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff <= `IMD_CTRL_RST;
        end else if (do_write && aw_addr_ff == `IMD_OFS_CTRL && w_strb_ff[0]) begin
            enable_ff <= w_data_ff[0];
        end
    end

    // Loading the primary word arms one decode; the extension word alone does not.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pending_ff <= 1'b0;
        end else begin
            pending_ff <= fetch_valid_i || (sw_op && w_strb_ff[1:0] != 2'h0);
        end
    end

    imd_op_t d_op;
    imd_size_t d_size;
    imd_tgt_t d_tgt;
    imd_bitop_t d_bitop;
    logic d_dir;
    logic d_illegal;
    logic [2:0] d_src_mode;
    logic [2:0] d_src_reg;
    logic [2:0] d_dst_mode;
    logic [2:0] d_dst_reg;

    imd_decode u_decode (
        .word_i(opword_ff),
        .ext_i(extword_ff),
        .op_o(d_op),
        .size_o(d_size),
        .tgt_o(d_tgt),
        .bitop_o(d_bitop),
        .dir_o(d_dir),
        .illegal_o(d_illegal),
        .src_mode_o(d_src_mode),
        .src_reg_o(d_src_reg),
        .dst_mode_o(d_dst_mode),
        .dst_reg_o(d_dst_reg)
    );

    // Captured results; with the enable clear the last result is kept and no pulse is sent.
    logic [31:0] result0_ff;
    logic [31:0] result1_ff;
    logic [15:0] count_ff;
    logic capture;
    assign capture = pending_ff && enable_ff;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result0_ff <= 32'h0;
            result1_ff <= 32'h0;
            dec_valid_o <= 1'b0;
            dec_op_o <= 4'h0;
            dec_size_o <= 2'h3;
            dec_illegal_o <= 1'b0;
        end else begin
            dec_valid_o <= capture;
            if (capture) begin
                result0_ff <= {15'h0, 1'b1, opword_ff[15:12], d_illegal, d_dir, d_bitop, d_tgt, d_size, d_op};
                result1_ff <= {8'h0, extword_ff[7:0], extword_ff[15:12], d_dst_mode, d_dst_reg,
                               d_src_mode, d_src_reg};
                dec_op_o <= d_op;
                dec_size_o <= d_size;
                dec_illegal_o <= d_illegal;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= 16'h0;
        end else if (capture) begin
            count_ff <= count_ff + 16'h1;
        end
    end

    // Read channel: one read in flight, answered the cycle after the address is taken.
    logic rvalid_ff;
    logic arready_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rd_mux;
    logic rd_hit;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0;
        unique case ({s_axi_araddr[7:2], 2'h0})
            `IMD_OFS_OPWORD: rd_mux = {16'h0, opword_ff};
            `IMD_OFS_EXTWORD: rd_mux = {16'h0, extword_ff};
            `IMD_OFS_CTRL: rd_mux = {31'h0, enable_ff};
            `IMD_OFS_RESULT0: rd_mux = result0_ff;
            `IMD_OFS_RESULT1: rd_mux = result1_ff;
            `IMD_OFS_COUNT: rd_mux = {16'h0, count_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= `IMD_RESP_OKAY;
            arready_ff <= 1'b1;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            arready_ff <= 1'b0;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_hit ? `IMD_RESP_OKAY : `IMD_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end
endmodule

// *** verification/imd_chk.sv ***
// Checker for imd_top: fetch decode timing, size and class results, bus answer timing.
// Assumes it is bound to imd_top and sees only that module's ports.
`timescale 1ns/1ps
module imd_chk (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset, active low
    input wire logic fetch_valid_i, // fetch strobe
    input wire logic [15:0] fetch_word_i, // primary word
    input wire logic dec_valid_o, // result pulse
    input wire logic [3:0] dec_op_o, // operation
    input wire logic [1:0] dec_size_o, // size
    input wire logic dec_illegal_o, // illegal word
    input wire logic s_axi_awvalid, // write address valid
    input wire logic s_axi_awready, // write address ready
    input wire logic s_axi_wvalid, // write data valid
    input wire logic s_axi_wready, // write data ready
    input wire logic s_axi_bvalid, // write response valid
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic s_axi_rvalid // read data valid
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic imm;
    logic [1:0] sz;
    assign sz = fetch_word_i[7:6];
    // Status-word forms reuse the low byte, so they are left out of the sized set.
    assign imm = fetch_word_i[15:12] == 4'h0 && !fetch_word_i[8] && fetch_word_i[11:9] != 3'h4
        && fetch_word_i[11:9] != 3'h7 && fetch_word_i[7:0] != 8'h3c && fetch_word_i[7:0] != 8'h7c;
    property p_pulse; fetch_valid_i |-> ##[2:3] dec_valid_o; endproperty
    a_pulse: assert property (p_pulse) else $error("decode pulse missing");
    property p_size;
        fetch_valid_i && imm && sz != 2'h3 |-> ##2 dec_valid_o && dec_size_o == $past(sz, 2) && !dec_illegal_o;
    endproperty
    a_size: assert property (p_size) else $error("immediate size wrong");
    property p_negate_with_extend;
        fetch_valid_i && fetch_word_i[15:8] == 8'h40 && sz != 2'h3 |->
            ##2 dec_valid_o && dec_op_o == 4'hb && dec_size_o == $past(sz, 2);
    endproperty
    a_negate_with_extend: assert property (p_negate_with_extend) else $error("negate size wrong");
    property p_ill; fetch_valid_i && imm && sz == 2'h3 |-> ##[2:3] dec_valid_o && dec_illegal_o; endproperty
    a_ill: assert property (p_ill) else $error("size 3 not illegal");
    property p_cop; fetch_valid_i && fetch_word_i[15:12] == 4'hf |-> ##[2:3] dec_valid_o && dec_op_o == 4'hc; endproperty
    a_cop: assert property (p_cop) else $error("coprocessor class wrong");
    property p_bit; fetch_valid_i && fetch_word_i[15:8] == 8'h08 |-> ##[2:3] dec_valid_o && dec_op_o == 4'h7; endproperty
    a_bit: assert property (p_bit) else $error("static bit class wrong");
    property p_mov; fetch_valid_i && fetch_word_i[15:12] == 4'h1 && fetch_word_i[8:6] != 3'h1 |->
        ##[2:3] dec_valid_o && dec_op_o == 4'h9 && !dec_illegal_o;
    endproperty
    a_mov: assert property (p_mov) else $error("byte move class wrong");
    property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write response late");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read data late");
endmodule
bind imd_top imd_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .fetch_valid_i(fetch_valid_i),
    .fetch_word_i(fetch_word_i), .dec_valid_o(dec_valid_o), .dec_op_o(dec_op_o), .dec_size_o(dec_size_o),
    .dec_illegal_o(dec_illegal_o), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// *** verification/imd_fetch_model.sv ***
// Fetch-side model: offers one primary word and its extension word for a single cycle.
// Assumes the decoder samples the pair at the rising edge where the strobe is high.
`timescale 1ns/1ps
module imd_fetch_model (
    input wire logic clk_i, // clock
    output logic valid_o, // word pair strobe
    output logic [15:0] word_o, // primary word
    output logic [15:0] ext_o // extension word
);
    initial begin
        valid_o = 1'b0;
        word_o = 16'h0;
        ext_o = 16'h0;
    end
    // After the strobe the words are inverted, so a decoder that samples late sees garbage.
    task automatic issue(input logic [15:0] w, input logic [15:0] e);
        @(posedge clk_i);
        valid_o <= 1'b1;
        word_o <= w;
        ext_o <= e;
        @(posedge clk_i);
        valid_o <= 1'b0;
        word_o <= ~w;
        ext_o <= ~e;
    endtask
endmodule

// *** verification/imd_top_tb.sv ***
// Self-checking bench for imd_top: fetch decodes and register readback over AXI4-Lite.
// Assumes the fetch model, the checker and the design are compiled before it.
`timescale 1ns/1ps
`include "imd_regs.svh"
module imd_top_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic fetch_valid_i, dec_valid_o, dec_illegal_o;
    logic [15:0] fetch_word_i, fetch_ext_i;
    logic [3:0] dec_op_o;
    logic [1:0] dec_size_o, s_axi_bresp, s_axi_rresp, r;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] ib [6] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h0a, 8'h0c};
    int errors = 0, total_checks = 0, nd = 0;
    always #5 clk_i = ~clk_i;
    imd_fetch_model u_fetch (.clk_i, .valid_o(fetch_valid_i), .word_o(fetch_word_i), .ext_o(fetch_ext_i));
    imd_top DUT (.clk_i, .rst_n_i, .fetch_valid_i, .fetch_word_i, .fetch_ext_i, .dec_valid_o, .dec_op_o,
        .dec_size_o, .dec_illegal_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // Handshakes are judged from values settled 1 ns after an edge, which hold until the next edge.
    // The bus tasks wait as long as the answer takes; a hung slave is left to the watchdog.
    task automatic bw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ha, hw, hb;
        hb = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!hb) begin
            #1;
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk_i);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic br(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ha, hr;
        hr = 1'b0;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!hr) begin
            #1;
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk_i);
            if (ha) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        br(a, d, r);
        chk(n, d & m, e);
    endtask
    task automatic opdec(input logic [15:0] w, input logic [15:0] e);
        bw(`IMD_OFS_EXTWORD, {16'h0, e}, r);
        bw(`IMD_OFS_OPWORD, {16'h0, w}, r);
        nd++;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic fchk(input logic [15:0] w, input logic [3:0] op, input logic [1:0] sz, input bit cs, input bit il);
        int n;
        u_fetch.issue(w, 16'h0);
        nd++;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (!dec_valid_o && n < 8);
        chk("dec_valid", dec_valid_o, 32'h1);
        chk("dec_illegal", dec_illegal_o, il);
        if (!il) chk("dec_op", dec_op_o, op);
        if (cs && !il) chk("dec_size", dec_size_o, sz);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #50000;
        errors++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk("size_reset", dec_size_o, 32'h3);
        rchk("ctrl_reset", `IMD_OFS_CTRL, 32'hffffffff, 32'h1);
        rchk("count_reset", `IMD_OFS_COUNT, 32'hffff, 32'h0);
        br(8'h20, d, r);
        chk("unmapped_data", d, 32'h0);
        chk("unmapped_resp", r, `IMD_RESP_SLVERR);
        bw(`IMD_OFS_RESULT0, 32'h1, r);
        chk("readonly_resp", r, `IMD_RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            for (int s = 0; s < 4; s++) begin
                fchk({ib[i], s[1:0], 6'h02}, 4'(i + 1), s[1:0], 1'b1, s == 3);
            end
        end
        for (int s = 0; s < 3; s++) fchk({8'h40, s[1:0], 6'h02}, 4'hb, s[1:0], 1'b1, 1'b0);
        fchk(16'h023c, 4'h2, 2'h0, 1'b1, 1'b0);
        fchk(16'h027c, 4'h2, 2'h1, 1'b1, 1'b0);
        fchk(16'hf000, 4'hc, 2'h0, 1'b0, 1'b0);
        fchk(16'h1083, 4'h9, 2'h0, 1'b0, 1'b0);
        fchk(16'h0842, 4'h7, 2'h0, 1'b0, 1'b0);
        fchk(16'h1040, 4'h9, 2'h0, 1'b0, 1'b1);
        for (int t = 0; t < 4; t++) begin
            opdec({8'h08, t[1:0], 6'h02}, 16'h0005);
            rchk("bit_type", `IMD_OFS_RESULT0, 32'h30f, {22'h0, t[1:0], 8'h07});
            rchk("bit_number", `IMD_OFS_RESULT1, 32'hff0000, 32'h50000);
        end
        for (int v = 0; v < 2; v++) begin
            opdec(16'h0e42, {4'h9, v[0], 11'h0});
            rchk("alt_dir", `IMD_OFS_RESULT0, 32'h40f, {21'h0, v[0], 10'h008});
        end
        opdec(16'h3a9c, 16'h0);
        rchk("move_fields", `IMD_OFS_RESULT1, 32'hffffff, 32'h55c);
        rchk("move_class", `IMD_OFS_RESULT0, 32'h1f00f, 32'h13009);
        rchk("count", `IMD_OFS_COUNT, 32'hffff, 32'(nd));
        // With the enable clear a new primary word must leave the last result, the count and dec_op_o alone.
        bw(`IMD_OFS_CTRL, 32'h0, r);
        chk("ctrl_resp", r, `IMD_RESP_OKAY);
        rchk("ctrl_off", `IMD_OFS_CTRL, 32'hffffffff, 32'h0);
        bw(`IMD_OFS_OPWORD, 32'hf000, r);
        repeat (3) @(posedge clk_i);
        rchk("held_result", `IMD_OFS_RESULT0, 32'h1f00f, 32'h13009);
        rchk("held_count", `IMD_OFS_COUNT, 32'hffff, 32'(nd));
        chk("held_op", dec_op_o, 32'h9);
        bw(`IMD_OFS_CTRL, 32'h1, r);
        final_report();
    end
endmodule
